// ---- hw/dia_info_store.sv ----
// device information store: read-only factory words behind two ports,
// an internal program-space read port and a wishbone classic slave.
// assumes one 20 mhz clock, inputs synchronous to it, and contents
// given as parameters that stand for the factory-programmed values.
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RL1: revision bits 15 to 12 always read the fixed family pattern 1010.
// RL2: revision bits 11 to 6 carry the six-bit major silicon revision.
// RL3: revision bits 5 to 0 carry the six-bit minor silicon revision.
// RL4: information area spans 3f0000 to 3f003f, fixed and read-only.
// RL5: six factory serial words start the area, forming one value.
// RL6: ten optional customer serial words sit at 3f0010 to 3f0023.
// RL7: word 3f0026 holds the low-range temperature reading at 90 c.
// RL8: word 3f002c holds the high-range temperature reading at 90 c.
// RL9: converter reference 1x, 2x, 4x in mv at 3f0030 onward.
// RL10: comparator reference 1x, 2x, 4x in mv at 3f0036 onward.
// RL11: part identifier word reads at 3ffffe and cannot be changed.
// RL12: revision word reads at 3ffffc and cannot be changed.
// RL13: writes to all these words are ignored; unassigned words read ffff.
module dia_info_store #(
    // arbitrary value, replaced per part at manufacture
    parameter logic [15:0] part_id_value = 16'h1234,
    parameter logic [5:0] major_rev_value = 6'h00,
    parameter logic [5:0] minor_rev_value = 6'h00,
    parameter logic [95:0] fac_serial_value = 96'h0,
    parameter logic [159:0] cust_serial_value = {160{1'b1}},
    parameter logic [15:0] temp_low_value = 16'h0000,
    parameter logic [15:0] temp_high_value = 16'h0000,
    parameter logic [47:0] conv_ref_value = 48'h1000_0800_0400,
    parameter logic [47:0] cmp_ref_value = 48'h1000_0800_0400
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire dia_pkg::dia_wb_req_type wb_req,
    output var dia_pkg::dia_wb_rsp_type wb_rsp,
    input wire logic rd_req,
    input wire logic [21:0] rd_addr,
    input wire logic wr_req,
    output logic rd_valid,
    output logic [15:0] rd_data
);
    import dia_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // contents

    // the area is held as words; a byte address names its even byte
    typedef logic [15:0] dia_word_type;
    dia_word_type area_rom [area_words];

    // where in program space an address falls; spare covers the gaps
    // inside the area that are left unprogrammed at manufacture
    typedef enum {
        region_fac_serial,
        region_cust_serial,
        region_temp_low,
        region_temp_high,
        region_conv_ref,
        region_cmp_ref,
        region_spare,
        region_part_id,
        region_revision,
        region_outside
    } dia_region_type;

    // which bus register a wishbone offset selects
    typedef enum {
        target_part_id,
        target_revision,
        target_pointer,
        target_data,
        target_none
    } dia_target_type;

    ////////////////////////////////////////////////////////////////////////
    // address arithmetic

    // word slot of a byte address inside the 64-byte area; the upper
    // bits are dropped on purpose, callers check the range first
    function automatic logic [4:0] word_index(input logic [21:0] a);
        return a[5:1];
    endfunction

    // word slot of the k-th word of a region that starts at base
    function automatic logic [4:0] slot(input logic [21:0] base,
                                        input int k);
        return word_index(base) + 5'(k);
    endfunction

    // program-space decode; odd bytes decode as the word holding them,
    // so a byte-wide reader sees both halves of every word
    function automatic dia_region_type region_of(input logic [21:0] a);
        logic [21:0] w;
        dia_region_type r;
        w = {a[21:1], 1'b0};
        r = region_outside;
        if (w >= fac_serial_first && w <= fac_serial_last) begin
            r = region_fac_serial; // see RL5
        end else if (w >= cust_serial_first && w <= cust_serial_last) begin
            r = region_cust_serial; // see RL6
        end else if (w == temp_low_addr) begin
            r = region_temp_low; // see RL7
        end else if (w == temp_high_addr) begin
            r = region_temp_high; // see RL8
        end else if (w >= conv_ref_first && w <= conv_ref_last) begin
            r = region_conv_ref; // see RL9
        end else if (w >= cmp_ref_first && w <= cmp_ref_last) begin
            r = region_cmp_ref; // see RL10
        end else if (w >= area_first && w <= area_last) begin
            r = region_spare; // see RL13
        end else if (w == part_id_addr) begin
            r = region_part_id; // see RL11
        end else if (w == revision_addr) begin
            r = region_revision; // see RL12
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // information area image

    // written out word by word so the layout reads like the map; the
    // parameters stand for values set at manufacture, and no port has
    // a path that writes here, which is what keeps the area read-only
    always_comb begin
        // gaps read as erased words
        for (int i = 0; i < area_words; i++) begin
            area_rom[i] = unassigned_word; // see RL13
        end

        // factory serial, lowest word first; all six form one value
        area_rom[slot(fac_serial_first, 0)] =
            fac_serial_value[15:0]; // see RL5
        area_rom[slot(fac_serial_first, 1)] =
            fac_serial_value[31:16]; // see RL5
        area_rom[slot(fac_serial_first, 2)] =
            fac_serial_value[47:32]; // see RL5
        area_rom[slot(fac_serial_first, 3)] =
            fac_serial_value[63:48]; // see RL5
        area_rom[slot(fac_serial_first, 4)] =
            fac_serial_value[79:64]; // see RL5
        area_rom[slot(fac_serial_first, 5)] =
            fac_serial_value[95:80]; // see RL5

        // customer serial; reads erased when the customer gave none
        area_rom[slot(cust_serial_first, 0)] =
            cust_serial_value[15:0]; // see RL6
        area_rom[slot(cust_serial_first, 1)] =
            cust_serial_value[31:16]; // see RL6
        area_rom[slot(cust_serial_first, 2)] =
            cust_serial_value[47:32]; // see RL6
        area_rom[slot(cust_serial_first, 3)] =
            cust_serial_value[63:48]; // see RL6
        area_rom[slot(cust_serial_first, 4)] =
            cust_serial_value[79:64]; // see RL6
        area_rom[slot(cust_serial_first, 5)] =
            cust_serial_value[95:80]; // see RL6
        area_rom[slot(cust_serial_first, 6)] =
            cust_serial_value[111:96]; // see RL6
        area_rom[slot(cust_serial_first, 7)] =
            cust_serial_value[127:112]; // see RL6
        area_rom[slot(cust_serial_first, 8)] =
            cust_serial_value[143:128]; // see RL6
        area_rom[slot(cust_serial_first, 9)] =
            cust_serial_value[159:144]; // see RL6

        // temperature readings; neighbouring slots stay erased
        area_rom[slot(temp_low_addr, 0)] =
            temp_low_value; // see RL7
        area_rom[slot(temp_high_addr, 0)] =
            temp_high_value; // see RL8

        // converter reference in mv: 1x, 2x, 4x
        area_rom[slot(conv_ref_first, 0)] =
            conv_ref_value[15:0]; // see RL9
        area_rom[slot(conv_ref_first, 1)] =
            conv_ref_value[31:16]; // see RL9
        area_rom[slot(conv_ref_first, 2)] =
            conv_ref_value[47:32]; // see RL9

        // comparator reference in mv: 1x, 2x, 4x
        area_rom[slot(cmp_ref_first, 0)] =
            cmp_ref_value[15:0]; // see RL10
        area_rom[slot(cmp_ref_first, 1)] =
            cmp_ref_value[31:16]; // see RL10
        area_rom[slot(cmp_ref_first, 2)] =
            cmp_ref_value[47:32]; // see RL10
    end

    // revision word assembled from fixed pattern and revision fields
    function automatic logic [15:0] revision_word();
        logic [15:0] w;
        w = 16'h0000;
        w[family_msb:family_lsb] = family_pattern; // see RL1
        w[major_msb:major_lsb] = major_rev_value; // see RL2
        w[minor_msb:minor_lsb] = minor_rev_value; // see RL3
        return w;
    endfunction

    // program-space lookup shared by both ports; anything that is not
    // mapped reads as an erased word rather than as zero
    function automatic logic [15:0] lookup(input logic [21:0] a);
        logic [15:0] v;
        v = unassigned_word;
        case (region_of(a))
            region_part_id: begin
                v = part_id_value; // see RL11
            end
            region_revision: begin
                v = revision_word(); // see RL12
            end
            region_outside: begin
                v = unassigned_word; // see RL13
            end
            default: begin
                v = area_rom[word_index(a)]; // see RL4
            end
        endcase
        return v;
    endfunction

    // wishbone register decode; offsets outside the four registers
    // answer with zero rather than an error, so a probe never hangs
    function automatic dia_target_type target_of(input logic [7:0] adr);
        dia_target_type t;
        t = target_none;
        if (adr == wb_part_id_off) begin
            t = target_part_id;
        end else if (adr == wb_revision_off) begin
            t = target_revision;
        end else if (adr == wb_prog_addr_off) begin
            t = target_pointer;
        end else if (adr == wb_prog_data_off) begin
            t = target_data;
        end
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic ack;
        logic [31:0] wb_dat;
        logic [21:0] prog_addr;
        logic rd_valid;
        logic [15:0] rd_data;
    } dia_state_type;

    dia_state_type state;
    dia_state_type next_state;
    logic wb_hit;

    // next state: one-cycle read port plus single-wait wishbone slave
    always_comb begin
        next_state = state;
        next_state.ack = 1'b0;
        next_state.rd_valid = 1'b0;
        wb_hit = wb_req.cyc && wb_req.stb && !state.ack;
        // a read with wr_req set is refused and gets no answer: contents never change, see RL13
        if (rd_req && !wr_req) begin
            next_state.rd_valid = 1'b1;
            next_state.rd_data = lookup(rd_addr);
        end
        // every access is acked once, one cycle after it is taken
        if (wb_hit) begin
            next_state.ack = 1'b1;
            case (target_of(wb_req.adr))
                target_part_id: begin
                    // writes drop silently, see RL13
                    next_state.wb_dat = {16'h0000, lookup(part_id_addr)};
                end
                target_revision: begin
                    // writes drop silently, see RL13
                    next_state.wb_dat = {16'h0000, lookup(revision_addr)};
                end
                target_pointer: begin
                    next_state.wb_dat = {10'h000, state.prog_addr};
                    // the address pointer is the only writable register
                    if (wb_req.we) begin
                        if (wb_req.sel[0]) begin
                            next_state.prog_addr[7:0] = wb_req.dat[7:0];
                        end
                        if (wb_req.sel[1]) begin
                            next_state.prog_addr[15:8] = wb_req.dat[15:8];
                        end
                        if (wb_req.sel[2]) begin
                            next_state.prog_addr[21:16] =
                                wb_req.dat[21:16];
                        end
                    end
                end
                target_data: begin
                    // writes drop silently, see RL13
                    next_state.wb_dat = {16'h0000, lookup(state.prog_addr)};
                end
                default: begin
                    next_state.wb_dat = unmapped_read;
                end
            endcase
        end
    end

    // one register stage for everything
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= '{ack: 1'b0, wb_dat: 32'h00000000,
                       prog_addr: prog_addr_reset, rd_valid: 1'b0,
                       rd_data: 16'h0000};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops

    assign wb_rsp.ack = state.ack;
    assign wb_rsp.dat = state.wb_dat;
    assign rd_valid = state.rd_valid;
    assign rd_data = state.rd_data;

endmodule
`default_nettype wire

// ---- hw/dia_pkg.sv ----
// package for the device information store: address map, word layout,
// revision fields and wishbone slave constants.
// assumes a byte-addressed program space of 22 bits and 16-bit words.
package dia_pkg;

    // program-space byte addresses of the information area
    localparam logic [21:0] area_first = 22'h3f0000;
    localparam logic [21:0] area_last = 22'h3f003f;
    localparam logic [21:0] fac_serial_first = 22'h3f0000;
    localparam logic [21:0] fac_serial_last = 22'h3f000b;
    localparam logic [21:0] cust_serial_first = 22'h3f0010;
    localparam logic [21:0] cust_serial_last = 22'h3f0023;
    localparam logic [21:0] temp_low_addr = 22'h3f0026;
    localparam logic [21:0] temp_high_addr = 22'h3f002c;
    localparam logic [21:0] conv_ref_first = 22'h3f0030;
    localparam logic [21:0] conv_ref_last = 22'h3f0034;
    localparam logic [21:0] cmp_ref_first = 22'h3f0036;
    localparam logic [21:0] cmp_ref_last = 22'h3f003a;
    localparam logic [21:0] revision_addr = 22'h3ffffc;
    localparam logic [21:0] part_id_addr = 22'h3ffffe;

    // wishbone register bus: word index = byte offset / 4
    localparam logic [7:0] wb_part_id_off = 8'h00;
    localparam logic [7:0] wb_revision_off = 8'h04;
    localparam logic [7:0] wb_prog_addr_off = 8'h08;
    localparam logic [7:0] wb_prog_data_off = 8'h0c;
    localparam logic [21:0] prog_addr_reset = 22'h3f0000;

    // word count of the information area (64 bytes, 32 words)
    localparam int area_words = 32;

    // revision word layout
    localparam logic [3:0] family_pattern = 4'ha;
    localparam int family_msb = 15;
    localparam int family_lsb = 12;
    localparam int major_msb = 11;
    localparam int major_lsb = 6;
    localparam int minor_msb = 5;
    localparam int minor_lsb = 0;

    // fill value for unassigned and unmapped locations
    localparam logic [15:0] unassigned_word = 16'hffff;
    localparam logic [31:0] unmapped_read = 32'h00000000;

    // one wishbone classic request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } dia_wb_req_type;

    // answer seen by the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } dia_wb_rsp_type;

endpackage

// ---- testbench/dia_reader.sv ----
// model of the internal reader on the program-space read port
// assumes fetch is called just after a rising clock edge
`timescale 1ns/10ps
`default_nettype none
module dia_reader (
    input wire logic clock,
    output logic rd_req = 1'b0,
    output logic [21:0] rd_addr = 22'h000000,
    output logic wr_req = 1'b0,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data
);
    // idle cycles first, so prompt and slow readers both occur
    task automatic fetch(input logic [21:0] a, input logic w, input int idle,
                         output logic [15:0] d, output bit got);
        got = 1'b0;
        d = 16'h0000;
        repeat (idle) @(posedge clock);
        rd_req <= 1'b1;
        rd_addr <= a;
        wr_req <= w;
        @(posedge clock);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        // bounded wait, a refused read simply never answers
        for (int i = 0; i < 3 && !got; i++) begin
            @(posedge clock);
            got = (rd_valid === 1'b1);
            d = rd_data;
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/dia_info_store_monitor.sv ----
// checker on the information store ports
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module dia_info_store_monitor (
    input wire logic clock,
    input wire logic reset_n,
    input wire dia_pkg::dia_wb_req_type wb_req,
    input wire dia_pkg::dia_wb_rsp_type wb_rsp,
    input wire logic rd_req,
    input wire logic [21:0] rd_addr,
    input wire logic wr_req,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data
);
    import dia_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // requests taken at this edge
    wire logic rd_go = rd_req && !wr_req;
    wire logic wb_go = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    wire logic wb_rd = wb_go && !wb_req.we;
    AST_RD_ANSWER: assert property (rd_go |=> rd_valid)
        else $error("no read answer");
    AST_WR_REFUSED: assert property (rd_req && wr_req |=> !rd_valid)
        else $error("write attempt answered");
    AST_RD_FAMILY: assert property (rd_go && rd_addr == revision_addr
        |=> rd_data[15:12] == family_pattern) else $error("family bits");
    AST_RD_UNASSIGNED: assert property (rd_go && rd_addr == 22'h3f0024
        |=> rd_data == unassigned_word) else $error("unassigned word");
    AST_RD_HOLD: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data moved");
    AST_WB_ACK: assert property (wb_go |=> wb_rsp.ack ##1 !wb_rsp.ack)
        else $error("ack timing");
    AST_WB_FAMILY: assert property (wb_rd && wb_req.adr == wb_revision_off
        |=> wb_rsp.dat[31:12] == {16'h0000, family_pattern}) else $error("family");
    AST_WB_UNMAPPED: assert property (wb_rd && wb_req.adr == 8'h10
        |=> wb_rsp.dat == unmapped_read) else $error("unmapped read");
    cover property (wb_go && wb_req.we);
    cover property (rd_req && wr_req);
    cover property (rd_go && rd_addr == revision_addr);
endmodule
`default_nettype wire

// ---- testbench/test_dia_info_store.sv ----
// bench: wishbone master, reader model, bound checker
// assumes package, design, reader and checker compile first
`timescale 1ns/10ps
`default_nettype none
module test_dia_info_store;
    import dia_pkg::*;
    localparam logic [15:0] pid = 16'h4b1d; // arbitrary value
    localparam logic [15:0] rev = {family_pattern, 6'h05, 6'h2a};
    localparam logic [95:0] fs = 96'h6006_5005_4004_3003_2002_1001;
    localparam logic [159:0] cs = 160'h0a0a_0909_0808_0707_0606_0505_0404_0303_0202_0101;
    localparam logic [95:0] rf = 96'h0ffe_07ce_03e6_0fa0_07d0_03e8;
    localparam logic [15:0] tl = 16'h0123;
    localparam logic [15:0] th = 16'h0456;
    logic clock, reset_n, rd_req, wr_req, rd_valid;
    logic [21:0] rd_addr, ad;
    logic [15:0] rd_data;
    logic [31:0] q;
    dia_wb_req_type wb_req;
    dia_wb_rsp_type wb_rsp;
    int n_fail = 0;
    int tests_run = 0;
    dia_info_store #(.part_id_value(pid), .major_rev_value(rev[11:6]),
        .minor_rev_value(rev[5:0]), .fac_serial_value(fs),
        .cust_serial_value(cs), .temp_low_value(tl), .temp_high_value(th),
        .conv_ref_value(rf[47:0]), .cmp_ref_value(rf[95:48])
    ) dut (.clock(clock), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
        .rd_valid(rd_valid), .rd_data(rd_data));
    dia_reader u_reader (.clock(clock), .rd_req(rd_req), .rd_addr(rd_addr),
        .wr_req(wr_req), .rd_valid(rd_valid), .rd_data(rd_data));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    // expected word at a byte address; odd bytes give their word
    function automatic logic [15:0] ew(input logic [21:0] a);
        logic [21:0] w;
        w = {a[21:1], 1'b0};
        if (w <= fac_serial_last) return fs[(w - area_first) * 8 +: 16];
        if (w >= cust_serial_first && w <= cust_serial_last)
            return cs[(w - cust_serial_first) * 8 +: 16];
        if (w == temp_low_addr) return tl;
        if (w == temp_high_addr) return th;
        if (w >= conv_ref_first && w <= cmp_ref_last)
            return rf[(w - conv_ref_first) * 8 +: 16];
        return unassigned_word;
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, d};
        for (n = 0; n < 8 && wb_rsp.ack !== 1'b1; n++) @(posedge clock);
        if (n == 8) begin
            n_fail++;
            report_and_stop();
        end
        r = wb_rsp.dat;
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rp(input logic [21:0] a, input logic w, input int idle,
                      input logic [15:0] exp);
        logic [15:0] d;
        bit got;
        u_reader.fetch(a, w, idle, d, got);
        chk({31'h0, got}, {31'h0, ~w});
        if (got == w) report_and_stop();
        if (!w) chk({16'h0, d}, {16'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        wb_req = '0;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        wb(1'b0, wb_prog_addr_off, 32'h0, q);
        chk(q, {10'h0, prog_addr_reset});
        wb(1'b0, wb_revision_off, 32'h0, q);
        chk(q, {16'h0, rev});
        // writes to read-only words must leave them intact
        wb(1'b1, wb_part_id_off, 32'h0000ffff, q);
        wb(1'b1, wb_revision_off, 32'h00000000, q);
        wb(1'b0, wb_part_id_off, 32'h0, q);
        chk(q, {16'h0, pid});
        wb(1'b0, wb_revision_off, 32'h0, q);
        chk(q, {16'h0, rev});
        wb(1'b0, 8'h10, 32'h0, q);
        chk(q, unmapped_read);
        wb(1'b1, wb_prog_addr_off, {10'h0, temp_high_addr}, q);
        wb(1'b0, wb_prog_data_off, 32'h0, q);
        chk(q, {16'h0, th});
        // every byte of the area, with varied reader pacing
        for (int a = 0; a < 64; a++) begin
            ad = area_first + 22'(a);
            rp(ad, 1'b0, a % 3, ew(ad));
        end
        rp(revision_addr, 1'b0, 0, rev);
        rp(part_id_addr, 1'b0, 0, pid);
        rp(temp_low_addr, 1'b1, 0, 16'h0);
        rp(temp_low_addr, 1'b0, 0, tl);
        report_and_stop();
    end
endmodule
bind dia_info_store dia_info_store_monitor u_mon (.clock(clock),
    .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .rd_req(rd_req),
    .rd_addr(rd_addr), .wr_req(wr_req), .rd_valid(rd_valid),
    .rd_data(rd_data));
`default_nettype wire
